/* common/homing_defines.vh */
/*
  Constants for the positive-direction homing sequencer: register offsets,
  field positions, reset values, method codes and timing counts.
  Assumes inclusion by bare name from the rtl files.
*/
`ifndef HOMING_DEFINES_VH
`define HOMING_DEFINES_VH

// Register byte offsets on the Wishbone slave
`define REG_CONFIG        4'h0
`define REG_CONTROL       4'h4
`define REG_STATUS        4'h8
`define REG_COUNTER2      4'hc

// Configuration field positions
`define CFG_METHOD_LSB    0
`define CFG_METHOD_MSB    3
`define CFG_PRESET_LSB    4
`define CFG_PRESET_MSB    7
`define CFG_LIMIT_STYLE   8
`define CFG_CLR_PULSE_EN  11
`define CFG_CLR1_BIT      20
`define CFG_CLR4_BIT      23
`define CFG_RESET         32'h0000_0000

// Control bits (write one to act)
`define CTL_START         0
`define CTL_STOP          1

// Method codes
`define METH_ORG          4'h0
`define METH_ORG_FA       4'h1
`define METH_ORG_IDX_DEC  4'h2
`define METH_ORG_IDX      4'h3
`define METH_ORG_REV_FA   4'h4
`define METH_ORG_REV_PAT  4'h5
`define METH_LIM_FA       4'h6
`define METH_LIM_IDX_FA   4'h7
`define METH_LIM_IDX_PAT  4'h8
`define METH_ZERO_0       4'h9
`define METH_ZERO_3       4'ha
`define METH_ZERO_5       4'hb
`define METH_ZERO_8       4'hc

// Start command code and pulse timing
`define CMD_HOME_PLUS     8'h10
`define PULSE_NS          1000
`define CLK_NS            20
`define PULSE_CYCLES      (`PULSE_NS / `CLK_NS)
// Last divider count, PULSE_CYCLES - 1 held at the divider's 6-bit width
`define PULSE_LAST        6'h31

`endif

/* rtl/edge_detect.v */
/*
  Registered edge detector for one input bit.
  Assumes the input is synchronous to clk_i.
*/
`timescale 1ns/1ns
module edge_detect (
  // Clock and reset
  input  wire clk_i,
  input  wire rst_i,
  // Sample and enable
  input  wire sample_en_i,
  input  wire level_i,
  // Edges
  output wire rise_o,
  output wire fall_o
);
  reg cur_q;
  reg prev_q;

  // Keep current and previous samples; enable lets callers sample slowly
  always @(posedge clk_i) begin
    if (rst_i) begin
      cur_q  <= 1'b0;
      prev_q <= 1'b0;
    end else if (sample_en_i) begin
      cur_q  <= level_i;
      prev_q <= cur_q;
    end
  end

  // One pulse per sample step
  assign rise_o = sample_en_i & cur_q & ~prev_q;
  assign fall_o = sample_en_i & ~cur_q & prev_q;
endmodule

/* rtl/index_counter.v */
/*
  Down-counter for encoder index rising edges.
  Assumes load and edge pulses are synchronous to clk_i.
*/
`timescale 1ns/1ns
module index_counter (
  // Clock and reset
  input  wire       clk_i,
  input  wire       rst_i,
  // Control
  input  wire       load_i,
  input  wire [3:0] preset_i,
  input  wire       count_en_i,
  input  wire       rise_i,
  // Result
  output wire       done_o,
  output wire [3:0] remain_o
);
  reg [3:0] cnt_q;
  reg       armed_q;

  // Preset 0 means one edge, 15 means sixteen
  always @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q   <= 4'h0;
      armed_q <= 1'b0;
    end else if (load_i) begin
      cnt_q   <= preset_i;
      armed_q <= 1'b1;
    end else if (count_en_i && rise_i && armed_q) begin
      if (cnt_q == 4'h0)
        armed_q <= 1'b0;
      else
        cnt_q <= cnt_q - 4'h1;
    end
  end

  assign done_o   = count_en_i & rise_i & armed_q & (cnt_q == 4'h0);
  assign remain_o = cnt_q;
endmodule

/* rtl/homing_sequencer_plus_dir.v */
/*
  Positive-direction homing sequencer with a Wishbone register slave.
  Assumes an external speed generator that honours run, dir, stop and
  decelerate requests and reports rest on motion_idle_i.
*/
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ns
`include "homing_defines.vh"
module homing_sequencer_plus_dir (
  // Clock and reset
  input  wire        clk_i,
  input  wire        rst_i,
  // Wishbone slave
  input  wire        cyc_i,
  input  wire        stb_i,
  input  wire        we_i,
  input  wire [3:0]  adr_i,
  input  wire [3:0]  sel_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] dat_o,
  output reg         ack_o,
  // Sensors
  input  wire        origin_sensor_i,
  input  wire        encoder_index_pulse_i,
  input  wire        plus_stroke_limit_i,
  input  wire        high_speed_pattern_i,
  input  wire        motion_idle_i,
  input  wire [31:0] counter2_value_i,
  // Motion requests
  output reg         run_o,
  output reg         dir_minus_o,
  output reg         aux_speed_o,
  output reg         stop_now_o,
  output reg         decel_stop_o,
  output reg         zero_return_o,
  output reg  [3:0]  counter_clear_o,
  output reg         deviation_clear_output_o,
  output reg         limit_abort_mask_o,
  output reg         pulse_o
);

  ////////////////////////////////////////////////////////////////////////////
  // States
  localparam [9:0] S_IDLE   = 10'h001;
  localparam [9:0] S_SEEK   = 10'h002;
  localparam [9:0] S_HALT1  = 10'h004;
  localparam [9:0] S_BACK   = 10'h008;
  localparam [9:0] S_HALT2  = 10'h010;
  localparam [9:0] S_FWD    = 10'h020;
  localparam [9:0] S_INDEX  = 10'h040;
  localparam [9:0] S_SETTLE = 10'h080;
  localparam [9:0] S_ZERO   = 10'h100;
  localparam [9:0] S_DONE   = 10'h200;

  reg  [31:0] config_q;
  reg  [9:0]  state_q;
  reg  [9:0]  state_d;
  reg  [5:0]  pdiv_q;
  reg         busy_q;
  reg         home_stop_q;
  wire [3:0]  method;
  wire [3:0]  base;
  wire        wb_req;
  wire        pulse_en;
  wire        org_rise;
  wire        org_fall;
  wire        lim_rise;
  wire        lim_fall;
  wire        idx_rise;
  wire        idx_done;
  wire [3:0]  idx_remain;
  wire        start_cmd;
  wire        stop_cmd;
  reg         idx_load;
  reg         idx_count_en;
  reg         stop_imm;
  reg         stop_dec;
  reg         clear_now;

  assign method = config_q[`CFG_METHOD_MSB:`CFG_METHOD_LSB];
  // Composite methods run their base method first
  assign base = (method == `METH_ZERO_0) ? `METH_ORG :
                (method == `METH_ZERO_3) ? `METH_ORG_IDX :
                (method == `METH_ZERO_5) ? `METH_ORG_REV_PAT :
                (method == `METH_ZERO_8) ? `METH_LIM_IDX_PAT : method;
  assign wb_req = cyc_i & stb_i & ~ack_o;
  assign start_cmd = wb_req & we_i & (adr_i == `REG_CONTROL) & sel_i[0] &
                     dat_i[`CTL_START] & ~busy_q;
  assign stop_cmd = wb_req & we_i & (adr_i == `REG_CONTROL) & sel_i[0] & dat_i[`CTL_STOP];

  ////////////////////////////////////////////////////////////////////////////
  // Pulse-rate divider: one enable per command pulse while running
  always @(posedge clk_i) begin
    if (rst_i || !run_o)
      pdiv_q <= 6'h0;
    else if (pdiv_q == `PULSE_LAST)
      pdiv_q <= 6'h0;
    else
      pdiv_q <= pdiv_q + 6'h1;
  end
  assign pulse_en = run_o & (pdiv_q == `PULSE_LAST);

  // Origin sensor sampled only in step with pulses, so an edge is flagged at the second pulse step after it
  edge_detect u_org (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sample_en_i (pulse_en),
    .level_i     (origin_sensor_i),
    .rise_o      (org_rise),
    .fall_o      (org_fall)
  );
  // Limit and index sampled every clock
  edge_detect u_lim (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sample_en_i (1'b1),
    .level_i     (plus_stroke_limit_i),
    .rise_o      (lim_rise),
    .fall_o      (lim_fall)
  );
  edge_detect u_idx (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .sample_en_i (1'b1),
    .level_i     (encoder_index_pulse_i),
    .rise_o      (idx_rise),
    .fall_o      ()
  );
  index_counter u_cnt (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (idx_load),
    .preset_i   (config_q[`CFG_PRESET_MSB:`CFG_PRESET_LSB]),
    .count_en_i (idx_count_en),
    .rise_i     (idx_rise),
    .done_o     (idx_done),
    .remain_o   (idx_remain)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer next state and stop requests
  always @* begin
    state_d      = state_q;
    idx_load     = 1'b0;
    idx_count_en = 1'b0;
    stop_imm     = 1'b0;
    stop_dec     = 1'b0;
    clear_now    = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (start_cmd) begin
          state_d  = S_SEEK;
          idx_load = 1'b1;
        end
      end
      S_SEEK: begin
        case (base)
          `METH_ORG: begin
            if (org_rise) begin
              // Patterns decelerate and rest past the origin
              stop_imm  = ~high_speed_pattern_i;
              stop_dec  = high_speed_pattern_i;
              clear_now = 1'b1;
              state_d   = S_SETTLE;
            end
          end
          `METH_ORG_FA, `METH_ORG_REV_FA, `METH_ORG_REV_PAT: begin
            if (org_rise) begin
              stop_imm = ~high_speed_pattern_i;
              stop_dec = high_speed_pattern_i;
              state_d  = S_HALT1;
            end
          end
          `METH_ORG_IDX_DEC: begin
            if (org_rise) begin
              stop_dec = high_speed_pattern_i;
              state_d  = S_INDEX;
            end
          end
          `METH_ORG_IDX: begin
            if (org_rise)
              state_d = S_INDEX;
          end
          `METH_LIM_FA, `METH_LIM_IDX_FA, `METH_LIM_IDX_PAT: begin
            if (lim_rise) begin
              stop_imm = ~(config_q[`CFG_LIMIT_STYLE] & high_speed_pattern_i);
              stop_dec = config_q[`CFG_LIMIT_STYLE] & high_speed_pattern_i;
              state_d  = S_HALT1;
            end
          end
          default: state_d = S_DONE;
        endcase
      end
      S_HALT1: begin
        if (motion_idle_i)
          state_d = S_BACK;
      end
      S_BACK: begin
        if ((base == `METH_ORG_FA) && org_fall) begin
          stop_imm = 1'b1;
          state_d  = S_HALT2;
        end else if ((base == `METH_LIM_FA) && lim_fall) begin
          stop_imm  = 1'b1;
          clear_now = 1'b1;
          state_d   = S_SETTLE;
        end else if ((base == `METH_ORG_REV_FA || base == `METH_ORG_REV_PAT) && org_fall) begin
          idx_load = 1'b1;
          state_d  = S_INDEX;
        end else if ((base == `METH_LIM_IDX_FA || base == `METH_LIM_IDX_PAT) && lim_fall) begin
          idx_load = 1'b1;
          state_d  = S_INDEX;
        end
      end
      S_HALT2: begin
        if (motion_idle_i)
          state_d = S_FWD;
      end
      S_FWD: begin
        if (org_rise) begin
          stop_imm  = 1'b1;
          clear_now = 1'b1;
          state_d   = S_SETTLE;
        end
      end
      S_INDEX: begin
        idx_count_en = 1'b1;
        if (idx_done) begin
          clear_now = 1'b1;
          // Methods 2, 4 and 7 cut even a deceleration short
          if (base == `METH_ORG_IDX_DEC || base == `METH_ORG_REV_FA || base == `METH_LIM_IDX_FA)
            stop_imm = 1'b1;
          else begin
            stop_imm = ~high_speed_pattern_i;
            stop_dec = high_speed_pattern_i;
          end
          state_d = S_SETTLE;
        end
      end
      S_SETTLE: begin
        if (motion_idle_i)
          state_d = (method >= `METH_ZERO_0 && method <= `METH_ZERO_8) ? S_ZERO : S_DONE;
      end
      S_ZERO: begin
        if (counter2_value_i == 32'h0) begin
          stop_imm = 1'b1;
          state_d  = S_DONE;
        end
      end
      S_DONE: begin
        if (motion_idle_i)
          state_d = S_IDLE;
      end
      default: state_d = S_IDLE;
    endcase
    if (stop_cmd && state_q != S_IDLE) begin
      stop_imm = 1'b1;
      state_d  = S_DONE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State and motion outputs
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q                  <= S_IDLE;
      busy_q                   <= 1'b0;
      home_stop_q              <= 1'b0;
      run_o                    <= 1'b0;
      dir_minus_o              <= 1'b0;
      aux_speed_o              <= 1'b0;
      stop_now_o               <= 1'b0;
      decel_stop_o             <= 1'b0;
      zero_return_o            <= 1'b0;
      counter_clear_o          <= 4'h0;
      deviation_clear_output_o <= 1'b0;
      limit_abort_mask_o       <= 1'b0;
      pulse_o                  <= 1'b0;
    end else begin
      state_q         <= state_d;
      busy_q          <= (state_d != S_IDLE);
      stop_now_o      <= stop_imm;
      decel_stop_o    <= stop_dec;
      pulse_o         <= pulse_en;
      // Run in SEEK, BACK, FWD, INDEX and ZERO; direction from phase
      run_o           <= (state_d == S_SEEK) | (state_d == S_BACK) | (state_d == S_FWD) |
                         (state_d == S_INDEX) | (state_d == S_ZERO);
      dir_minus_o     <= (state_d == S_BACK) |
                         ((state_d == S_INDEX) && (state_q != S_SEEK) && !(state_q == S_INDEX && !dir_minus_o)) |
                         (state_d == S_ZERO);
      aux_speed_o     <= (state_d == S_BACK || state_d == S_FWD || state_d == S_INDEX) &&
                         (base == `METH_ORG_FA || base == `METH_ORG_REV_FA ||
                          base == `METH_LIM_FA || base == `METH_LIM_IDX_FA);
      zero_return_o   <= (state_d == S_ZERO);
      // Limit homing must not abort on the plus limit
      limit_abort_mask_o <= (state_d != S_IDLE) &&
                            (base == `METH_LIM_FA || base == `METH_LIM_IDX_FA ||
                             base == `METH_LIM_IDX_PAT);
      counter_clear_o <= clear_now ? config_q[`CFG_CLR4_BIT:`CFG_CLR1_BIT] : 4'h0;
      deviation_clear_output_o <= clear_now & config_q[`CFG_CLR_PULSE_EN];
      if (clear_now)
        home_stop_q <= 1'b1;
      else if (start_cmd)
        home_stop_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one registered ack per request, one cycle after it
  always @(posedge clk_i) begin
    if (rst_i) begin
      config_q <= `CFG_RESET;
      ack_o    <= 1'b0;
      dat_o    <= 32'h0;
    end else begin
      ack_o <= wb_req;
      if (wb_req && we_i && adr_i == `REG_CONFIG) begin
        if (sel_i[0]) config_q[7:0]   <= dat_i[7:0];
        if (sel_i[1]) config_q[15:8]  <= dat_i[15:8];
        if (sel_i[2]) config_q[23:16] <= dat_i[23:16];
        if (sel_i[3]) config_q[31:24] <= dat_i[31:24];
      end
      if (wb_req && !we_i) begin
        case (adr_i)
          `REG_CONFIG:   dat_o <= config_q & 32'h00f0_09ff;
          `REG_STATUS:   dat_o <= {16'h0, idx_remain, 1'b0, home_stop_q, state_q};
          `REG_COUNTER2: dat_o <= counter2_value_i;
          default:       dat_o <= 32'h0;
        endcase
      end
    end
  end
endmodule

/* test/homing_sequencer_properties.sv */
/*
  Concurrent checks on the homing sequencer ports: bus answer timing, stop,
  clear and pulse behaviour against a shadow of the configuration word.
  Assumes full-word configuration writes and one clock with synchronous reset.
*/
`timescale 1ns/1ns
`include "homing_defines.vh"
module homing_sequencer_properties (
  // Clock and reset
  input wire        clk_i,
  input wire        rst_i,
  // Bus
  input wire        cyc_i,
  input wire        stb_i,
  input wire        we_i,
  input wire [3:0]  adr_i,
  input wire [31:0] dat_i,
  input wire        ack_o,
  // Motion requests
  input wire        run_o,
  input wire        stop_now_o,
  input wire        decel_stop_o,
  input wire        zero_return_o,
  input wire [3:0]  counter_clear_o,
  input wire        deviation_clear_output_o,
  input wire        limit_abort_mask_o,
  input wire        pulse_o
);
  reg [31:0] cfg_q;

  // Shadow of the configuration, taken only at the acknowledging edge
  always @(posedge clk_i) begin
    if (rst_i) begin
      cfg_q <= `CFG_RESET;
    end else if (cyc_i && stb_i && we_i && ack_o && adr_i == `REG_CONFIG) begin
      cfg_q <= dat_i;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_in_one: assert property ((cyc_i && stb_i && !ack_o) |=> ack_o)
    else $error("ack missing one cycle after request");
  a_ack_one_wide: assert property (ack_o |=> !ack_o)
    else $error("ack wider than one cycle");
  a_stop_single: assert property (stop_now_o |=> !stop_now_o)
    else $error("stop pulse wider than one cycle");
  a_stop_ends_run: assert property (stop_now_o |=> !run_o)
    else $error("run still requested after stop");
  a_clear_on_stop: assert property ((counter_clear_o != 4'h0) |-> (stop_now_o || decel_stop_o))
    else $error("counter clear without a stop");
  a_clear_per_cfg: assert property ((counter_clear_o != 4'h0) |-> counter_clear_o == cfg_q[23:20])
    else $error("counter clear bits differ from configuration");
  a_erc_gated: assert property (deviation_clear_output_o |-> cfg_q[`CFG_CLR_PULSE_EN])
    else $error("deviation clear while disabled");
  a_pulse_spaced: assert property (pulse_o |=> !pulse_o [*8])
    else $error("command pulses too close");
  a_mask_methods: assert property (limit_abort_mask_o |-> cfg_q[3:0] inside {4'h6, 4'h7, 4'h8, 4'hc})
    else $error("limit mask in a non-limit method");
  a_zero_methods: assert property (zero_return_o |-> cfg_q[3:0] >= 4'h9)
    else $error("zero return in a plain method");
  a_reset_quiet: assert property ($fell(rst_i) |-> (!run_o && !ack_o && !pulse_o))
    else $error("outputs active after reset");

  c_decel: cover property (decel_stop_o);
  c_zero: cover property (zero_return_o);
  c_erc: cover property (deviation_clear_output_o);
endmodule

/* test/motion_partner_model.sv */
/*
  Axis model: one step per command pulse, origin sensor, index and plus limit
  from position, counter 2 and a rest flag with selectable lag.
  Assumes the sequencer drops run at each stop phase.
*/
`timescale 1ns/1ns
module motion_partner_model (
  // Clock and test control
  input  wire               clk_i,
  input  wire               rst_i,
  input  wire               home_i,
  input  wire [3:0]         lat_i,
  // Requests from the sequencer
  input  wire               run_i,
  input  wire               dir_minus_i,
  input  wire               pulse_i,
  input  wire               clear2_i,
  // Sensors and feedback
  output wire               origin_sensor_o,
  output wire               encoder_index_pulse_o,
  output wire               plus_stroke_limit_o,
  output wire               motion_idle_o,
  output wire [31:0]        counter2_value_o,
  output reg  signed [31:0] pos_o = 32'sh0
);
  reg signed [31:0] c2_q = 32'sh0;
  reg [3:0]         idle_cnt_q = 4'h0;
  wire signed [31:0] step = pulse_i ? (dir_minus_i ? -32'sd1 : 32'sd1) : 32'sd0;

  // Position and counter 2 follow pulses; home teleports the axis to zero
  always @(posedge clk_i) begin
    if (rst_i || home_i) begin
      pos_o <= 32'sh0;
      c2_q  <= 32'sh0;
    end else begin
      pos_o <= pos_o + step;
      c2_q  <= clear2_i ? 32'sh0 : c2_q + step;
    end
    idle_cnt_q <= run_i ? 4'h0 : (idle_cnt_q == 4'hf ? idle_cnt_q : idle_cnt_q + 4'h1);
  end

  // Rest comes late by lat_i cycles, so a slow drive is exercised too
  assign motion_idle_o = !run_i && (idle_cnt_q >= lat_i);
  // Origin spans several pulses of travel, wider than one sampling step
  assign origin_sensor_o = (pos_o >= 10) && (pos_o <= 13);
  assign encoder_index_pulse_o = (pos_o[2:0] == 3'h5);
  assign plus_stroke_limit_o = (pos_o >= 32);
  assign counter2_value_o = c2_q;
endmodule

/* test/homing_sequencer_plus_dir_tb_top.sv */
/*
  Testbench: runs every homing method with random configuration, plus an
  aborted run, against the axis model. Assumes a 50 MHz clock.
*/
`timescale 1ns/1ns
`include "homing_defines.vh"
module homing_sequencer_plus_dir_tb_top;
  logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, hs = 1'b0, home = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'hf, lat = 4'h1;
  logic [31:0] dat_i = 32'h0, seed = 32'h57f1, idle_code, q;
  wire  [31:0] dat_o, counter2_value_i;
  wire  signed [31:0] pos;
  wire  [3:0]  counter_clear_o;
  wire ack_o, run_o, dir_minus_o, aux_speed_o, stop_now_o, decel_stop_o, zero_return_o, pulse_o;
  wire deviation_clear_output_o, limit_abort_mask_o, motion_idle_i;
  wire origin_sensor_i, encoder_index_pulse_i, plus_stroke_limit_i;
  int fail_count = 0, n_checks = 0, clr_n = 0, erc_n = 0, mask_n = 0, zr_n = 0, aux_n = 0, dir_n = 0, clr_v, clr_k;
  logic signed [31:0] clr_p;

  homing_sequencer_plus_dir DUT (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .origin_sensor_i, .encoder_index_pulse_i, .plus_stroke_limit_i, .high_speed_pattern_i(hs),
    .motion_idle_i, .counter2_value_i, .run_o, .dir_minus_o, .aux_speed_o, .stop_now_o, .decel_stop_o,
    .zero_return_o, .counter_clear_o, .deviation_clear_output_o, .limit_abort_mask_o, .pulse_o);
  motion_partner_model axis (.clk_i, .rst_i, .home_i(home), .lat_i(lat), .run_i(run_o), .dir_minus_i(dir_minus_o),
    .pulse_i(pulse_o), .clear2_i(counter_clear_o[1]), .origin_sensor_o(origin_sensor_i),
    .encoder_index_pulse_o(encoder_index_pulse_i), .plus_stroke_limit_o(plus_stroke_limit_i),
    .motion_idle_o(motion_idle_i), .counter2_value_o(counter2_value_i), .pos_o(pos));

  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////
  // Event tally; tasks diff snapshots so nothing clears it mid-edge
  always @(posedge clk_i) begin
    if (counter_clear_o != 4'h0) begin
      clr_n++;
      clr_v = counter_clear_o;
      clr_p = pos;
      clr_k = stop_now_o ? 1 : (decel_stop_o ? 2 : 0);
    end
    erc_n += deviation_clear_output_o;
    mask_n += limit_abort_mask_o;
    zr_n += zero_return_o;
    aux_n += aux_speed_o;
    dir_n += dir_minus_o;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Where the clear lands: origin 10..13, index every 8 from 5, limit at 32
  function automatic int exp_pos(input int m, input int p);
    case (m)
      0, 1, 9: return 10;
      2, 3, 10: return 13 + 8 * p;
      4, 5, 11: return 5 - 8 * p;
      6: return 31;
      default: return 29 - 8 * p;
    endcase
  endfunction

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Sensor sampling on pulse steps allows one step of slack
  task automatic near(input string nm, input int e, input logic signed [31:0] g);
    n_checks++;
    if ($isunknown(g) || g > e + 1 || g < e - 1) begin
      fail_count++;
      $display("BAD %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 50);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
    chk("bus_ack", 1'b1, ack_o);
  endtask

  task automatic run_method(input int m, input logic ab);
    logic [31:0] cfg, r;
    logic [3:0]  cl;
    int p, c0, e0, k0, z0, a0, d0, n;
    repeat (4) seed = lfsr(seed);
    p = (m > 8) ? 0 : seed[0];
    cl = {seed[7:5], 1'b1};
    if (m > 8) cl[1] = 1'b0;
    cfg = {8'h00, cl, 8'h00, seed[11], 2'b00, seed[8], p[3:0], m[3:0]};
    @(posedge clk_i);
    home <= 1'b1;
    hs <= seed[9];
    lat <= {1'b0, seed[14:12]} + 4'h1;
    @(posedge clk_i);
    home <= 1'b0;
    wb(1'b1, `REG_CONFIG, cfg, r);
    wb(1'b0, `REG_CONFIG, 32'h0, r);
    chk("config", cfg, r & 32'h00f0_09ff);
    c0 = clr_n;
    e0 = erc_n;
    k0 = mask_n;
    z0 = zr_n;
    a0 = aux_n;
    d0 = dir_n;
    wb(1'b1, `REG_CONTROL, 32'h1, r);
    if (ab) begin
      repeat (300) @(posedge clk_i);
      wb(1'b1, `REG_CONTROL, 32'h2, r);
    end
    n = 0;
    do begin
      repeat (20) @(posedge clk_i);
      wb(1'b0, `REG_STATUS, 32'h0, r);
      n++;
    end while (r[9:0] !== idle_code[9:0] && n < 400);
    chk("finished", 1, n < 400);
    chk("home_stop", !ab, r[10]);
    if (ab) begin
      chk("abort_clears", 0, clr_n - c0);
    end else begin
      chk("clears", 1, clr_n - c0);
      chk("clear_bits", cl, clr_v);
      chk("stop_kind", (seed[9] && m inside {0, 3, 5, 8, 9, 10, 11, 12}) ? 2 : 1, clr_k);
      near("clear_pos", exp_pos(m, p), clr_p);
      chk("erc", cfg[11], erc_n != e0);
      chk("limit_mask", m inside {6, 7, 8, 12}, mask_n != k0);
      chk("zero_return", m > 8, zr_n != z0);
      chk("aux_speed", m inside {1, 4, 6, 7}, aux_n != a0);
      chk("reverse", !(m inside {0, 2, 3}), dir_n != d0);
      if (m > 8) begin
        near("final_pos", 0, pos);
        wb(1'b0, `REG_COUNTER2, 32'h0, r);
        chk("counter2", 32'h0, r);
      end
    end
    $display("test method %0d abort %0d done", m, ab);
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk("run_after_reset", 1'b0, run_o);
    wb(1'b0, `REG_CONFIG, 32'h0, q);
    chk("config_reset", `CFG_RESET, q);
    wb(1'b0, 4'h2, 32'h0, q);
    chk("unmapped_read", 32'h0, q);
    wb(1'b0, `REG_STATUS, 32'h0, idle_code);
    $display("test register reset done");
    for (int m = 0; m < 13; m++) run_method(m, 1'b0);
    run_method(0, 1'b1);
    report_and_stop();
  end

  // Watchdog sized well above thirteen full homing runs
  initial begin
    repeat (95000) @(posedge clk_i);
    fail_count++;
    report_and_stop();
  end
endmodule

bind homing_sequencer_plus_dir homing_sequencer_properties u_props (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
  .adr_i, .dat_i, .ack_o, .run_o, .stop_now_o, .decel_stop_o, .zero_return_o, .counter_clear_o,
  .deviation_clear_output_o, .limit_abort_mask_o, .pulse_o);
